// *** logic/anpd_regs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef ANPD_REGS_SVH
`define ANPD_REGS_SVH
`define ANPD_REG_CTRL   5'h00
`define ANPD_REG_STAT   5'h01
`define ANPD_REG_ADV    5'h04
`define ANPD_REG_LPA    5'h05
`define ANPD_REG_EXP    5'h06
`define ANPD_REG_QSTAT  5'h11
`define ANPD_REG_XSTAT  5'h13
`define ANPD_CTRL_SRST  15
`define ANPD_CTRL_SPD   13
`define ANPD_CTRL_ANEN  12
`define ANPD_CTRL_RSTRT 9
`define ANPD_CTRL_FDX   8
`define ANPD_STAT_ANC   5
`define ANPD_STAT_RF    4
`define ANPD_STAT_ANA   3
`define ANPD_STAT_LINK  2
`define ANPD_AB_RF      13
`define ANPD_AB_T4      9
`define ANPD_AB_100FD   8
`define ANPD_AB_100HD   7
`define ANPD_AB_10FD    6
`define ANPD_AB_10HD    5
`define ANPD_EXP_PDF    4
`define ANPD_EXP_LPAN   0
`define ANPD_Q_SPD      15
`define ANPD_Q_FDX      14
`define ANPD_Q_ANC      4
`define ANPD_Q_NOSIG    3
`define ANPD_Q_RF       1
`define ANPD_Q_LINK     0
`define ANPD_X_RF       13
`define ANPD_ADV_RST    16'h01e1
`define ANPD_PRE_ONES   6'h20
`define ANPD_CLK_NS     10
`define ANPD_LISTEN_NS  50000000
`define ANPD_LISTEN_CYC ((`ANPD_LISTEN_NS + `ANPD_CLK_NS - 1) / `ANPD_CLK_NS)
`endif

// *** logic/anpd_pkg.sv ***
// types of the negotiation and parallel detection block
package anpd_pkg;
   typedef enum logic [2:0] {AN_IDLE, AN_LISTEN, AN_RESOLVE, AN_PDET, AN_DONE} anpd_an_t;
   typedef enum logic [2:0] {MD_PRE, MD_HDR, MD_TA, MD_RD, MD_WR} anpd_md_t;
   typedef struct packed {
      logic [1:0]  mdc_sy;
      logic        mdc_d;
      logic [1:0]  mdio_sy;
      logic [4:0]  phy_s1;
      logic [4:0]  phy_s2;
      anpd_md_t    md;
      logic [5:0]  ones;
      logic [5:0]  cnt;
      logic        rd_op;
      logic [15:0] sh;
      logic [15:0] rd;
      logic [4:0]  rreg;
      logic        mdio_out;
      logic        mdio_oe;
      logic        soft_rst;
      logic        restart;
      logic        an_en;
      logic        spd;
      logic        fdx;
      logic [15:0] adv;
      logic [15:0] lpa;
      logic        lp_an;
      logic        pd_fault;
      logic        rf;
      logic        anc;
      logic        no_sig;
      anpd_an_t    an;
      logic [31:0] timer;
      logic        tx_flp;
      logic        sel100;
      logic        selfdx;
      logic        en100;
      logic        en10;
      logic [15:0] tx_page;
   } anpd_state_t;
endpackage : anpd_pkg

// *** logic/anpd_top.sv ***
// negotiation arbitration, parallel detection and management registers
`include "anpd_regs.svh"

module anpd_top
   import anpd_pkg::*;
#(
   parameter int unsigned P_LISTEN_CYC = `ANPD_LISTEN_CYC
) (
   // clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_reset_n,
   // serial management pins
   input  wire logic        i_mdc,
   input  wire logic        i_mdio,
   output logic             o_mdio,
   output logic             o_mdio_oe,
   input  wire logic [4:0]  i_phy_addr,
   // line-side detectors
   input  wire logic [15:0] i_rx_page,
   input  wire logic        i_rx_page_vld,
   input  wire logic        i_nlp_seen,
   input  wire logic        i_idle100_seen,
   input  wire logic        i_signal_present,
   input  wire logic        i_link_fail,
   input  wire logic        i_local_fault,
   // technology control
   output logic [15:0]      o_tx_page,
   output logic             o_tx_flp_en,
   output logic             o_en_100,
   output logic             o_en_10,
   output logic             o_full_duplex,
   output logic             o_mii_rate_100,
   output logic             o_an_complete
);

   anpd_state_t s_r;
   anpd_state_t s_nxt;
   logic        rise;
   logic        fall;
   logic        mbit;
   logic [15:0] hsh;
   logic [3:0]  common;

   // register read decode
   function automatic logic [15:0] rd_reg(input anpd_state_t s, input logic [4:0] a);
      logic [15:0] v;
      v = 16'h0000;
      case (a)
         `ANPD_REG_CTRL: begin
            v[`ANPD_CTRL_SPD]  = s.spd;
            v[`ANPD_CTRL_ANEN] = s.an_en;
            v[`ANPD_CTRL_FDX]  = s.fdx;
         end
         `ANPD_REG_STAT: begin
            v[`ANPD_STAT_ANC]  = s.anc;
            v[`ANPD_STAT_RF]   = s.rf;
            v[`ANPD_STAT_ANA]  = 1'b1;
            v[`ANPD_STAT_LINK] = s.anc;
         end
         `ANPD_REG_ADV:  v = s.tx_page;
         `ANPD_REG_LPA:  v = s.lpa;
         `ANPD_REG_EXP: begin
            v[`ANPD_EXP_PDF]  = s.pd_fault;
            v[`ANPD_EXP_LPAN] = s.lp_an;
         end
         `ANPD_REG_QSTAT: begin
            v[`ANPD_Q_SPD]   = s.sel100;
            v[`ANPD_Q_FDX]   = s.selfdx;
            v[`ANPD_Q_ANC]   = s.anc;
            v[`ANPD_Q_NOSIG] = s.no_sig;
            v[`ANPD_Q_RF]    = s.rf;
            v[`ANPD_Q_LINK]  = s.anc;
         end
         `ANPD_REG_XSTAT: v[`ANPD_X_RF] = s.rf;
         default:         v = 16'h0000;
      endcase
      return v;
   endfunction : rd_reg

   // next-state logic for the whole block
   always_comb begin
      s_nxt = s_r;
      hsh   = 16'h0000;
      // management pins pass two flops before anything reads them
      s_nxt.mdc_sy  = {s_r.mdc_sy[0], i_mdc};
      s_nxt.mdc_d   = s_r.mdc_sy[1];
      s_nxt.mdio_sy = {s_r.mdio_sy[0], i_mdio};
      s_nxt.phy_s1  = i_phy_addr;
      s_nxt.phy_s2  = s_r.phy_s1;
      rise = s_r.mdc_sy[1] & ~s_r.mdc_d;
      fall = ~s_r.mdc_sy[1] & s_r.mdc_d;
      mbit = s_r.mdio_sy[1];
      s_nxt.soft_rst = 1'b0;
      s_nxt.restart  = 1'b0;

      // management frame engine: sample on mdc rise, drive on mdc fall
      case (s_r.md)
         MD_PRE: begin
            if (rise) begin
               if (mbit) begin
                  if (s_r.ones != `ANPD_PRE_ONES) begin
                     s_nxt.ones = s_r.ones + 6'h01;
                  end
               end else begin
                  if (s_r.ones == `ANPD_PRE_ONES) begin
                     s_nxt.md  = MD_HDR;
                     s_nxt.cnt = 6'h00;
                  end
                  s_nxt.ones = 6'h00;
               end
            end
         end
         MD_HDR: begin
            if (rise) begin
               hsh      = {s_r.sh[14:0], mbit};
               s_nxt.sh = hsh;
               s_nxt.cnt = s_r.cnt + 6'h01;
               if (s_r.cnt == 6'h0c) begin
                  s_nxt.cnt  = 6'h00;
                  s_nxt.rreg = hsh[4:0];
                  s_nxt.md   = MD_PRE;
                  // foreign address or bad opcode: stay off the wire
                  if (hsh[12] && hsh[9:5] == s_r.phy_s2) begin
                     if (hsh[11:10] == 2'b10) begin
                        s_nxt.md    = MD_TA;
                        s_nxt.rd_op = 1'b1;
                        s_nxt.rd    = rd_reg(s_r, hsh[4:0]);
                        // latched bits clear on read; later sets override
                        if (hsh[4:0] == `ANPD_REG_STAT || hsh[4:0] == `ANPD_REG_QSTAT
                            || hsh[4:0] == `ANPD_REG_XSTAT) begin
                           s_nxt.rf = 1'b0;
                        end
                        if (hsh[4:0] == `ANPD_REG_EXP) begin
                           s_nxt.pd_fault = 1'b0;
                        end
                     end else if (hsh[11:10] == 2'b01) begin
                        s_nxt.md    = MD_TA;
                        s_nxt.rd_op = 1'b0;
                     end
                  end
               end
            end
         end
         MD_TA: begin
            if (s_r.rd_op && fall) begin
               s_nxt.cnt = s_r.cnt + 6'h01;
               if (s_r.cnt == 6'h01) begin
                  s_nxt.mdio_oe  = 1'b1;
                  s_nxt.mdio_out = 1'b0;
                  s_nxt.md       = MD_RD;
                  s_nxt.cnt      = 6'h00;
               end
            end else if (!s_r.rd_op && rise) begin
               s_nxt.cnt = s_r.cnt + 6'h01;
               if (s_r.cnt == 6'h01) begin
                  s_nxt.md  = MD_WR;
                  s_nxt.cnt = 6'h00;
               end
            end
         end
         MD_RD: begin
            if (fall) begin
               if (s_r.cnt == 6'h10) begin
                  s_nxt.mdio_oe  = 1'b0;
                  s_nxt.mdio_out = 1'b0;
                  s_nxt.md       = MD_PRE;
               end else begin
                  s_nxt.mdio_out = s_r.rd[15];
                  s_nxt.rd       = {s_r.rd[14:0], 1'b0};
                  s_nxt.cnt      = s_r.cnt + 6'h01;
               end
            end
         end
         MD_WR: begin
            if (rise) begin
               hsh       = {s_r.sh[14:0], mbit};
               s_nxt.sh  = hsh;
               s_nxt.cnt = s_r.cnt + 6'h01;
               if (s_r.cnt == 6'h0f) begin
                  s_nxt.md = MD_PRE;
                  case (s_r.rreg)
                     `ANPD_REG_CTRL: begin
                        s_nxt.an_en    = hsh[`ANPD_CTRL_ANEN];
                        s_nxt.spd      = hsh[`ANPD_CTRL_SPD];
                        s_nxt.fdx      = hsh[`ANPD_CTRL_FDX];
                        s_nxt.soft_rst = hsh[`ANPD_CTRL_SRST];
                        s_nxt.restart  = hsh[`ANPD_CTRL_RSTRT];
                     end
                     `ANPD_REG_ADV: s_nxt.adv = hsh;
                     default: s_nxt.md = MD_PRE;
                  endcase
               end
            end
         end
         default: s_nxt.md = MD_PRE;
      endcase

      // line observations
      s_nxt.no_sig = ~i_signal_present;
      common = s_r.adv[`ANPD_AB_100FD:`ANPD_AB_10HD] & s_r.lpa[`ANPD_AB_100FD:`ANPD_AB_10HD];

      // arbitration
      case (s_r.an)
         AN_IDLE: begin
            s_nxt.tx_flp = 1'b0;
            if (s_r.an_en) begin
               s_nxt.an    = AN_LISTEN;
               s_nxt.timer = 32'h0000_0000;
               s_nxt.anc   = 1'b0;
               s_nxt.en100 = 1'b0;
               s_nxt.en10  = 1'b0;
            end
         end
         AN_LISTEN: begin
            s_nxt.tx_flp = 1'b1;
            s_nxt.timer  = s_r.timer + 32'h0000_0001;
            if (i_rx_page_vld) begin
               s_nxt.lpa   = i_rx_page;
               s_nxt.lp_an = 1'b1;
               s_nxt.an    = AN_RESOLVE;
               if (i_rx_page[`ANPD_AB_RF]) begin
                  s_nxt.rf = 1'b1;
               end
            end else if (i_nlp_seen && i_idle100_seen) begin
               // ambiguous line: enable nothing and keep trying
               s_nxt.pd_fault = 1'b1;
               s_nxt.en100    = 1'b0;
               s_nxt.en10     = 1'b0;
               s_nxt.timer    = 32'h0000_0000;
            end else if (i_nlp_seen) begin
               s_nxt.sel100 = 1'b0;
               s_nxt.an     = AN_PDET;
            end else if (i_idle100_seen) begin
               s_nxt.sel100 = 1'b1;
               s_nxt.an     = AN_PDET;
            end else if (s_r.timer >= 32'(P_LISTEN_CYC - 1)) begin
               s_nxt.timer = 32'h0000_0000;
            end
         end
         AN_RESOLVE: begin
            s_nxt.tx_flp = 1'b0;
            s_nxt.an     = AN_DONE;
            s_nxt.anc    = 1'b1;
            // fixed priority; the 100 Mb/s four-pair mode is never chosen
            if (common[3]) begin
               s_nxt.sel100 = 1'b1;
               s_nxt.selfdx = 1'b1;
            end else if (common[2]) begin
               s_nxt.sel100 = 1'b1;
               s_nxt.selfdx = 1'b0;
            end else if (common[1]) begin
               s_nxt.sel100 = 1'b0;
               s_nxt.selfdx = 1'b1;
            end else if (common[0]) begin
               s_nxt.sel100 = 1'b0;
               s_nxt.selfdx = 1'b0;
            end else begin
               s_nxt.an     = AN_LISTEN;
               s_nxt.anc    = 1'b0;
               s_nxt.timer  = 32'h0000_0000;
            end
            if (common != 4'h0) begin
               s_nxt.en100 = common[3] | common[2];
               s_nxt.en10  = ~(common[3] | common[2]);
            end
         end
         AN_PDET: begin
            s_nxt.tx_flp = 1'b0;
            s_nxt.lp_an  = 1'b0;
            s_nxt.selfdx = 1'b0;
            if (s_r.sel100) begin
               s_nxt.lpa[`ANPD_AB_100HD] = 1'b1;
            end else begin
               s_nxt.lpa[`ANPD_AB_10HD] = 1'b1;
            end
            s_nxt.anc   = 1'b1;
            s_nxt.en100 = s_r.sel100;
            s_nxt.en10  = ~s_r.sel100;
            s_nxt.an    = AN_DONE;
         end
         AN_DONE: begin
            s_nxt.tx_flp = 1'b0;
            if (i_link_fail) begin
               s_nxt.restart = 1'b1;
            end
         end
         default: s_nxt.an = AN_IDLE;
      endcase

      // restart or disable: machine back to idle, sticky status kept
      if (s_r.restart || !s_r.an_en) begin
         s_nxt.an     = AN_IDLE;
         s_nxt.tx_flp = 1'b0;
         s_nxt.anc    = 1'b0;
         s_nxt.timer  = 32'h0000_0000;
      end
      if (!s_r.an_en) begin
         // forced mode follows the control bits directly
         s_nxt.sel100 = s_r.spd;
         s_nxt.selfdx = s_r.fdx;
         s_nxt.en100  = s_r.spd;
         s_nxt.en10   = ~s_r.spd;
      end

      // software reset: as the hardware reset on the negotiation state and registers; sel100, selfdx and the frame engine keep their values
      if (s_r.soft_rst) begin
         s_nxt.an       = AN_IDLE;
         s_nxt.timer    = 32'h0000_0000;
         s_nxt.tx_flp   = 1'b0;
         s_nxt.anc      = 1'b0;
         s_nxt.lp_an    = 1'b0;
         s_nxt.pd_fault = 1'b0;
         s_nxt.rf       = 1'b0;
         s_nxt.lpa      = 16'h0000;
         s_nxt.en100    = 1'b0;
         s_nxt.en10     = 1'b0;
         s_nxt.an_en    = 1'b1;
         s_nxt.spd      = 1'b1;
         s_nxt.fdx      = 1'b1;
         s_nxt.adv      = `ANPD_ADV_RST;
      end

      // outgoing word carries the local fault as remote fault
      s_nxt.tx_page = s_nxt.adv;
      s_nxt.tx_page[`ANPD_AB_RF] = s_nxt.adv[`ANPD_AB_RF] | i_local_fault;
   end

   // single state register
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         s_r         <= '0;
         s_r.an_en   <= 1'b1;
         s_r.spd     <= 1'b1;
         s_r.fdx     <= 1'b1;
         s_r.adv     <= `ANPD_ADV_RST;
         s_r.tx_page <= `ANPD_ADV_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from the state flops
   assign o_mdio         = s_r.mdio_out;
   assign o_mdio_oe      = s_r.mdio_oe;
   assign o_tx_page      = s_r.tx_page;
   assign o_tx_flp_en    = s_r.tx_flp;
   assign o_en_100       = s_r.en100;
   assign o_en_10        = s_r.en10;
   assign o_full_duplex  = s_r.selfdx;
   assign o_mii_rate_100 = s_r.sel100;
   assign o_an_complete  = s_r.anc;

endmodule : anpd_top

// *** dv/anpd_chk.sv ***
// assertion checker watching the ports of the negotiation block
module anpd_chk #(
   parameter int unsigned P_LISTEN_CYC = 16
) (
   // clock and reset
   input wire logic        i_core_clk,
   input wire logic        i_reset_n,
   // line-side detectors
   input wire logic [15:0] i_rx_page,
   input wire logic        i_rx_page_vld,
   input wire logic        i_nlp_seen,
   input wire logic        i_idle100_seen,
   input wire logic        i_local_fault,
   // technology control
   input wire logic [15:0] o_tx_page,
   input wire logic        o_tx_flp_en,
   input wire logic        o_en_100,
   input wire logic        o_en_10,
   input wire logic        o_full_duplex,
   input wire logic        o_mii_rate_100,
   input wire logic        o_an_complete
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] up_r;

   // settle count so that $past never looks back into reset
   always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         up_r <= 2'h0;
      end else if (up_r != 2'h3) begin
         up_r <= up_r + 2'h1;
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);

   // outputs tied to their causes on the line
   property p_fault_adv;
      up_r == 2'h3 && $past(i_local_fault) |-> o_tx_page[13];
   endproperty
   a_fault_adv: assert property (p_fault_adv) else $error("local fault not advertised");
   property p_one_tech;
      o_en_100 |-> !o_en_10;
   endproperty
   a_one_tech: assert property (p_one_tech) else $error("two technologies enabled");
   property p_listen_off;
      o_tx_flp_en |-> !o_en_100 && !o_en_10;
   endproperty
   a_listen_off: assert property (p_listen_off) else $error("technology on while listening");
   property p_rate;
      (o_en_100 || o_en_10) |-> o_mii_rate_100 == o_en_100;
   endproperty
   a_rate: assert property (p_rate) else $error("nibble rate mismatch");
   property p_done_tech;
      $rose(o_an_complete) |-> o_en_100 ^ o_en_10;
   endproperty
   a_done_tech: assert property (p_done_tech) else $error("complete without technology");
   property p_nlp;
      o_tx_flp_en && i_nlp_seen && !i_idle100_seen && !i_rx_page_vld
         |-> ##[2:3] o_an_complete && o_en_10;
   endproperty
   a_nlp: assert property (p_nlp) else $error("link pulses not taken as 10M partner");
   property p_idle;
      o_tx_flp_en && i_idle100_seen && !i_nlp_seen && !i_rx_page_vld
         |-> ##[2:3] o_an_complete && o_en_100 && !o_full_duplex;
   endproperty
   a_idle: assert property (p_idle) else $error("idles not taken as 100M partner");
   property p_mixed;
      o_tx_flp_en && i_nlp_seen && i_idle100_seen
         |-> ##1 (!o_en_100 && !o_en_10 && !o_an_complete) [*2];
   endproperty
   a_mixed: assert property (p_mixed) else $error("technology enabled on mixed signals");
   property p_page_fd;
      o_tx_flp_en && i_rx_page_vld && o_tx_page[8] && i_rx_page[8]
         |-> ##[2:3] o_an_complete && o_en_100 && o_full_duplex;
   endproperty
   a_page_fd: assert property (p_page_fd) else $error("top priority not chosen");
endmodule : anpd_chk

bind anpd_top anpd_chk #(.P_LISTEN_CYC(P_LISTEN_CYC)) u_anpd_chk (
   .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_rx_page(i_rx_page),
   .i_rx_page_vld(i_rx_page_vld), .i_nlp_seen(i_nlp_seen), .i_idle100_seen(i_idle100_seen),
   .i_local_fault(i_local_fault), .o_tx_page(o_tx_page), .o_tx_flp_en(o_tx_flp_en),
   .o_en_100(o_en_100), .o_en_10(o_en_10), .o_full_duplex(o_full_duplex),
   .o_mii_rate_100(o_mii_rate_100), .o_an_complete(o_an_complete)
);

// *** dv/anpd_partner.sv ***
// remote link partner model on the cable side
module anpd_partner (
   // clock
   input  wire logic        i_core_clk,
   // commands: 0 silent, 1 bursts, 2 link pulses, 3 idles, 4 pulses and idles
   input  wire logic [2:0]  i_mode,
   input  wire logic [15:0] i_word,
   input  wire logic [7:0]  i_dly,
   // cable view
   input  wire logic        i_flp,
   output logic [15:0]      o_page,
   output logic             o_page_vld,
   output logic             o_nlp,
   output logic             o_idle,
   output logic             o_sig
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       flp_r;
   logic [7:0] cnt_r;

   initial begin
      o_page = 16'h0000;
      o_page_vld = 1'b0;
      flp_r = 1'b0;
      cnt_r = 8'h00;
   end

   // legacy partners signal all the time, whatever the device sends
   assign o_nlp = i_mode == 3'h2 || i_mode == 3'h4;
   assign o_idle = i_mode == 3'h3 || i_mode == 3'h4;
   assign o_sig = i_mode != 3'h0;

   // one word per burst episode after a delay; the word line scrambles otherwise
   always @(posedge i_core_clk) begin
      flp_r <= i_flp;
      o_page_vld <= 1'b0;
      o_page <= ~o_page;
      if (i_flp && !flp_r) begin
         cnt_r <= i_dly;
      end else if (cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
      end
      if (cnt_r == 8'h01 && i_mode == 3'h1) begin
         o_page_vld <= 1'b1;
         o_page <= i_word;
      end
   end
endmodule : anpd_partner

// *** dv/anpd_top_tb.sv ***
// self-checking bench for the negotiation block
`define CHK_EQ(what, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("unexpected %s expected %h seen %h", what, (exp), (got)); \
      end \
   end

module anpd_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [4:0] PHY = 5'h01;
   logic clk = 1'b0;
   logic rst_n, mdc, tb_oe, tb_d, lf, lfail;
   logic [2:0] mode;
   logic [15:0] word;
   logic [7:0] dly;
   wire mdio_w, o_mdio, o_mdio_oe, rx_vld, nlp, idle, sig;
   wire o_tx_flp_en, o_en_100, o_en_10, o_full_duplex, o_mii_rate_100, o_an_complete;
   wire [15:0] rx_page, o_tx_page;
   int bad_count = 0;
   int comparisons = 0;

   always #5 clk = ~clk;
   // pull-up on the data pin while nobody drives it
   assign mdio_w = o_mdio_oe ? o_mdio : (tb_oe ? tb_d : 1'b1);

   anpd_top #(.P_LISTEN_CYC(16)) u_anpd_top (
      .i_core_clk(clk), .i_reset_n(rst_n), .i_mdc(mdc), .i_mdio(mdio_w), .o_mdio(o_mdio),
      .o_mdio_oe(o_mdio_oe), .i_phy_addr(PHY), .i_rx_page(rx_page), .i_rx_page_vld(rx_vld),
      .i_nlp_seen(nlp), .i_idle100_seen(idle), .i_signal_present(sig), .i_link_fail(lfail),
      .i_local_fault(lf), .o_tx_page(o_tx_page), .o_tx_flp_en(o_tx_flp_en),
      .o_en_100(o_en_100), .o_en_10(o_en_10), .o_full_duplex(o_full_duplex),
      .o_mii_rate_100(o_mii_rate_100), .o_an_complete(o_an_complete));
   anpd_partner u_anpd_partner (
      .i_core_clk(clk), .i_mode(mode), .i_word(word), .i_dly(dly), .i_flp(o_tx_flp_en),
      .o_page(rx_page), .o_page_vld(rx_vld), .o_nlp(nlp), .o_idle(idle), .o_sig(sig));

   task automatic stop_test;
      if (bad_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test

   // one management clock period of 22 core cycles, slow enough for the 2-flop sync
   task automatic mbit(input logic oe, input logic b, output logic s);
      @(posedge clk);
      mdc <= 1'b0;
      tb_oe <= oe;
      tb_d <= b;
      repeat (11) @(posedge clk);
      s = mdio_w;
      mdc <= 1'b1;
      repeat (10) @(posedge clk);
   endtask : mbit

   // full frame with preamble; op 2'b01 writes, 2'b10 reads
   task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                        output logic [15:0] rv);
      logic [13:0] hdr;
      logic [17:0] tail;
      logic s;
      hdr = {2'b01, op, PHY, ra};
      tail = {2'b10, wd};
      rv = 16'h0000;
      for (int i = 0; i < 32; i++) mbit(1'b1, 1'b1, s);
      for (int i = 13; i >= 0; i--) mbit(1'b1, hdr[i], s);
      for (int i = 17; i >= 0; i--) begin
         mbit(op == 2'b01, tail[i], s);
         rv = {rv[14:0], s};
      end
      mbit(1'b0, 1'b1, s);
   endtask : frame

   task automatic rchk(input logic [4:0] ra, input logic [15:0] mask, input logic [15:0] exp);
      logic [15:0] v;
      frame(2'b10, ra, 16'h0000, v);
      `CHK_EQ($sformatf("register %0h", ra), exp, v & mask)
   endtask : rchk

   task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
      logic [15:0] v;
      frame(2'b01, ra, wd, v);
   endtask : wr

   // set the partner, restart negotiation, wait a bounded time for completion
   task automatic neg(input logic [2:0] m, input logic [15:0] w, input logic [7:0] d);
      @(posedge clk);
      mode <= m;
      word <= w;
      dly <= d;
      wr(5'h00, 16'h1200);
      for (int i = 0; i < 300 && o_an_complete !== 1'b1; i++) @(posedge clk);
      repeat (3) @(posedge clk);
   endtask : neg

   task automatic t_start;
      `CHK_EQ("tx page", 16'h01e1, o_tx_page)
      `CHK_EQ("bursts and enables", 3'b100, {o_tx_flp_en, o_en_100, o_en_10})
      rchk(5'h04, 16'hffff, 16'h01e1);
      rchk(5'h01, 16'h0020, 16'h0000);
      rchk(5'h11, 16'h0018, 16'h0008);
      rchk(5'h1f, 16'hffff, 16'h0000);
   endtask : t_start

   task automatic t_priority;
      logic [15:0] pages [4] = '{16'h01e1, 16'h00a1, 16'h0061, 16'h0021};
      logic [2:0] want [4] = '{3'b101, 3'b100, 3'b011, 3'b010};
      for (int i = 0; i < 4; i++) begin
         neg(3'h1, pages[i], i[0] ? 8'h0c : 8'h01);
         `CHK_EQ("chosen tech", want[i], {o_en_100, o_en_10, o_full_duplex})
         `CHK_EQ("nibble rate", want[i][2], o_mii_rate_100)
         `CHK_EQ("complete", 1'b1, o_an_complete)
         rchk(5'h05, 16'hffff, pages[i]);
         rchk(5'h06, 16'h0001, 16'h0001);
      end
   endtask : t_priority

   // each status read clears the shared fault latch, so renegotiate before every status read
   task automatic t_rfault;
      logic [4:0] ra [3] = '{5'h01, 5'h13, 5'h11};
      logic [15:0] bm [3] = '{16'h0030, 16'h2000, 16'h0012};
      for (int i = 0; i < 3; i++) begin
         neg(3'h1, 16'h2021, 8'h03);
         rchk(ra[i], bm[i] | {12'h000, i == 2, 3'h0}, bm[i]);
      end
      rchk(5'h05, 16'h2000, 16'h2000);
   endtask : t_rfault

   task automatic t_adv;
      wr(5'h04, 16'h0021);
      @(posedge clk);
      lf <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK_EQ("advertised word", 16'h2021, o_tx_page)
      lf <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK_EQ("advertised word", 16'h0021, o_tx_page)
      neg(3'h1, 16'h01e1, 8'h02);
      `CHK_EQ("chosen tech", 3'b010, {o_en_100, o_en_10, o_full_duplex})
   endtask : t_adv

   task automatic t_softrst;
      @(posedge clk);
      mode <= 3'h0;
      wr(5'h00, 16'h8000);
      `CHK_EQ("complete", 1'b0, o_an_complete)
      rchk(5'h04, 16'hffff, 16'h01e1);
      rchk(5'h05, 16'hffff, 16'h0000);
   endtask : t_softrst

   task automatic t_pardet;
      for (int i = 0; i < 2; i++) begin
         neg(i ? 3'h3 : 3'h2, 16'h0000, 8'h01);
         `CHK_EQ("chosen tech", i ? 3'b100 : 3'b010, {o_en_100, o_en_10, o_full_duplex})
         `CHK_EQ("complete", 1'b1, o_an_complete)
         rchk(5'h05, i ? 16'h0080 : 16'h00a0, i ? 16'h0080 : 16'h0020);
      end
      neg(3'h1, 16'h0021, 8'h01);
      neg(3'h2, 16'h0000, 8'h01);
      rchk(5'h06, 16'h0001, 16'h0000);
   endtask : t_pardet

   task automatic t_pdfault;
      @(posedge clk);
      mode <= 3'h4;
      wr(5'h00, 16'h1200);
      `CHK_EQ("enables", 3'b000, {o_en_100, o_en_10, o_an_complete})
      rchk(5'h06, 16'h0010, 16'h0010);
      mode <= 3'h2;
      for (int i = 0; i < 300 && o_an_complete !== 1'b1; i++) @(posedge clk);
      `CHK_EQ("link pulse tech", 3'b011, {o_en_100, o_en_10, o_an_complete})
      mode <= 3'h0;
      lfail <= 1'b1;
      @(posedge clk);
      lfail <= 1'b0;
      repeat (10) @(posedge clk);
      `CHK_EQ("restart", 2'b01, {o_an_complete, o_tx_flp_en})
      wr(5'h00, 16'h2100);
      `CHK_EQ("forced tech", 3'b101, {o_en_100, o_en_10, o_full_duplex})
      wr(5'h00, 16'h1000);
      `CHK_EQ("restart", 2'b01, {o_an_complete, o_tx_flp_en})
   endtask : t_pdfault

   initial begin
      rst_n = 1'b0;
      mdc = 1'b1;
      tb_oe = 1'b0;
      tb_d = 1'b1;
      lf = 1'b0;
      lfail = 1'b0;
      mode = 3'h0;
      word = 16'h0000;
      dly = 8'h01;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_start();
      t_priority();
      t_rfault();
      t_adv();
      t_softrst();
      t_pardet();
      t_pdfault();
      stop_test();
   end

   // watchdog: about 60k cycles expected, cut off at 90k
   initial begin
      #900000;
      bad_count++;
      stop_test();
   end
endmodule : anpd_top_tb
